// ### verilog/core_pins_dev.sv
/*
  Core end of the test and miscellaneous pins: scan chains, qualified bus
  write sequencer, endianness, interrupt intake, vector base and a debug
  tick counter with its own asynchronous reset.
  Assumes every link input is synchronous to pclk and that the far end
  holds bus_reset_n low for at least one edge after power-up.
*/
`timescale 1ns/1ns
`include "core_pins_regs.svh"
module core_pins_dev #(
  parameter int CHAIN_LEN = `SCAN_LEN
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  core_pins_if.dev                        link,
  input  wire logic                       big_endian_mode,
  input  wire logic                       xfer_req,
  input  wire logic [31:0]                xfer_addr,
  input  wire logic [7:0]                 xfer_byte,
  output logic                            xfer_busy,
  output logic                            xfer_done,
  output logic                            vector_base_high,
  output logic [31:0]                     irq_vector,
  output core_pins_pkg::irq_kind_t        irq_kind,
  output logic [15:0]                     debug_ticks
);
  import core_pins_pkg::*;

  // ========================================================================
  // Scan chains.
  logic [`SCAN_CHAINS-1:0] chain_out;

  // Each chain is an independent shift register with its own in and out pins; all share one shift enable.
  for (genvar i = 0; i < `SCAN_CHAINS; i++)
  begin : g_chain
    scan_chain #(
      .LEN      (CHAIN_LEN)
    ) u_chain (
      .pclk     (pclk),
      .presetn  (presetn),
      .shift_en (link.scan_shift_enable),           // [RULE_02]
      .scan_in  (link.scan_chain_in[i]),            // [RULE_03]
      .scan_out (chain_out[i])
    );
  end

  assign link.scan_chain_out = chain_out;

  // ========================================================================
  // Bus write sequencer.
  xfer_state_t state_q;
  xfer_state_t state_d;
  logic [31:0] addr_q;
  logic [31:0] addr_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0]  strb_q;
  logic [3:0]  strb_d;
  logic        valid_q;
  logic        valid_d;
  logic        done_q;
  logic        done_d;
  logic        busy_q;
  logic        busy_d;
  logic        endian_q;
  logic        bus_edge;
  logic [1:0]  lane;

  // While scan forces the clocks free-running, every edge counts as a bus
  // edge so that the sequencer cannot hang waiting for an enable.
  assign bus_edge = link.bus_clock_enable | link.scan_clock_force; // [RULE_05]

  // Byte lane in the word: big-endian mirrors the low address bits so the
  // least significant lane sits at the highest address.
  assign lane = endian_q ? (`BYTE_LANE_TOP - xfer_addr[1:0])
                         : xfer_addr[1:0];                      // [RULE_13]

  always_comb
  begin
    state_d = state_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    strb_d  = strb_q;
    valid_d = valid_q;
    done_d  = 1'b0;
    if (!link.bus_reset_n)
    begin
      state_d = XFER_IDLE;                                       // [RULE_08]
      valid_d = 1'b0;
    end
    else
    begin
      unique case (state_q)
        XFER_IDLE:
        begin
          if (xfer_req)
          begin
            addr_d  = xfer_addr;
            wdata_d = {4{xfer_byte}};
            strb_d  = `STRB_ONE << lane;
            state_d = XFER_ADDR;
          end
        end
        XFER_ADDR:
        begin
          if (bus_edge)
          begin
            valid_d = 1'b1;                                      // [RULE_05]
            state_d = XFER_DATA;
          end
        end
        XFER_DATA:
        begin
          if (bus_edge)
          begin
            valid_d = 1'b0;                                      // [RULE_05]
            done_d  = 1'b1;
            state_d = XFER_IDLE;
          end
        end
      endcase
    end
    // Busy is registered so that the pin comes straight from a flop.
    busy_d = (state_d != XFER_IDLE);
  end

  // All sequencer state moves on the rising edge only.
  always_ff @(posedge pclk or negedge presetn)                  // [RULE_04]
  begin
    if (!presetn)
    begin
      state_q <= XFER_IDLE;
      addr_q  <= '0;
      wdata_q <= '0;
      strb_q  <= '0;
      valid_q <= 1'b0;
      done_q  <= 1'b0;
      busy_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      strb_q  <= strb_d;
      valid_q <= valid_d;
      done_q  <= done_d;
      busy_q  <= busy_d;
    end
  end

  assign link.bus_valid = valid_q;
  assign link.bus_addr  = addr_q;
  assign link.bus_wdata = wdata_q;
  assign link.bus_strb  = strb_q;
  assign xfer_busy      = busy_q;
  assign xfer_done      = done_q;

  // ========================================================================
  // Endianness, vector base bit and interrupt intake.
  logic        endian_d;
  logic        vbit_q;
  logic        vbit_d;
  irq_kind_t   kind_q;
  irq_kind_t   kind_d;
  logic [31:0] vec_q;
  logic [31:0] vec_d;
  logic [31:0] base;

  assign base = vbit_q ? `VEC_BASE_HIGH : `VEC_BASE_LOW;          // [RULE_14]

  always_comb
  begin
    endian_d = big_endian_mode;                                  // [RULE_10]
    vbit_d   = vbit_q;
    // The strap is sampled for as long as the bus reset is held, so the
    // bit settles to the strap level present at the release.
    if (!link.bus_reset_n)
    begin
      vbit_d = link.vector_init_strap;                           // [RULE_11]
    end
    // Fast requests win over normal ones when both are low.
    kind_d = IRQ_NONE;
    vec_d  = base;
    if (!link.fast_irq_n)
    begin
      kind_d = IRQ_FAST;                                         // [RULE_12]
      vec_d  = base + `VEC_OFF_FIQ;
    end
    else if (!link.normal_irq_n)
    begin
      kind_d = IRQ_NORMAL;                                       // [RULE_12]
      vec_d  = base + `VEC_OFF_IRQ;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      endian_q <= 1'b0;
      vbit_q   <= `VBIT_RESET;
      kind_q   <= IRQ_NONE;
      vec_q    <= `VEC_BASE_LOW;
    end
    else
    begin
      endian_q <= endian_d;
      vbit_q   <= vbit_d;
      kind_q   <= kind_d;
      vec_q    <= vec_d;
    end
  end

  assign link.endian_big_out = endian_q;                         // [RULE_10]
  assign vector_base_high    = vbit_q;
  assign irq_kind            = kind_q;
  assign irq_vector          = vec_q;

  // ========================================================================
  // Debug tick counter.
  logic        dbg_rst_n;
  logic [15:0] ticks_q;
  logic [15:0] ticks_d;

  // Either reset clears the debug state; the debug reset needs no clock.
  // Both inputs come from flops, so the AND cannot glitch low spuriously.
  assign dbg_rst_n = presetn & link.debug_reset_n;               // [RULE_09]

  always_comb
  begin
    ticks_d = ticks_q;
    if (link.debug_clock_enable)
    begin
      ticks_d = ticks_q + 16'h0001;                              // [RULE_07]
    end
  end

  always_ff @(posedge pclk or negedge dbg_rst_n)
  begin
    if (!dbg_rst_n)
    begin
      ticks_q <= '0;                                             // [RULE_09]
    end
    else
    begin
      ticks_q <= ticks_d;
    end
  end

  assign debug_ticks = ticks_q;

endmodule : core_pins_dev

// ### verilog/core_pins_regs.svh
/*
  Constants shared by both ends of the core test and miscellaneous pins:
  vector addresses, scan geometry, controller register map and fields.
  Assumes it is included by bare name from the verilog/ folder.
*/
// Function
// RULE_01: Clock force high in scan, low otherwise.
// RULE_02: Shift enable high shifts scan chains.
// RULE_03: Seven scan chains, own in and out.
// RULE_04: Everything timed from rising system clock.
// RULE_05: Bus transfers advance only on enabled edges.
// RULE_06: Same-rate bus ties bus enable high.
// RULE_07: Debug enable gates debug logic, high in scan.
// RULE_08: Bus reset low resets bus logic.
// RULE_09: Debug reset clears internal state asynchronously.
// RULE_10: Endian output high for big-endian.
// RULE_11: Strap loads vector-base bit at reset.
// RULE_12: Accept active-low fast and normal interrupts.
// RULE_13: Big-endian puts low byte at higher address.
// RULE_14: Vector base zero or top 64 KB.
// RULE_15: Each chain moves one bit per edge.
`ifndef CORE_PINS_REGS_SVH
`define CORE_PINS_REGS_SVH

// ==========================================================================
// Device constants
`define SCAN_CHAINS     7
`define SCAN_LEN        16
`define VEC_BASE_LOW    32'h0000_0000
`define VEC_BASE_HIGH   32'hFFFF_0000
`define VEC_OFF_IRQ     32'h0000_0018
`define VEC_OFF_FIQ     32'h0000_001C
`define VBIT_RESET      1'h0
`define BYTE_LANE_TOP   2'h3
`define STRB_ONE        4'h1

// ==========================================================================
// Controller register offsets (APB byte addresses)
`define REG_CTRL        12'h000
`define REG_DIV         12'h004
`define REG_SCAN        12'h008
`define REG_BUS_ADDR    12'h00C
`define REG_BUS_DATA    12'h010
`define REG_BUS_STRB    12'h014

// Control register fields and reset value.
`define CTRL_TEST       0
`define CTRL_BUS_RUN    1
`define CTRL_DBG_RUN    2
`define CTRL_FIQ        3
`define CTRL_IRQ        4
`define CTRL_STRAP      5
`define CTRL_DBG_EN     6
`define CTRL_W          7
`define CTRL_RESET      7'h00
`define DIV_W           8
`define DIV_RESET       8'h00
// Status bit in the scan register, above the seven scan bits.
`define SCAN_ENDIAN     8

`endif

// ### verilog/core_pins_pkg.sv
/*
  Types shared by both ends of the core test and miscellaneous pins.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package core_pins_pkg;

  // ========================================================================
  // Bus transfer sequencer states.
  typedef enum logic [1:0] {XFER_IDLE, XFER_ADDR, XFER_DATA} xfer_state_t;

  // Interrupt currently presented to the core.
  typedef enum logic [1:0] {IRQ_NONE, IRQ_NORMAL, IRQ_FAST} irq_kind_t;

endpackage : core_pins_pkg

// ### verilog/core_pins_if.sv
/*
  Link between the core end and the system integration end.
  Assumes both ends run on the same pclk; no clocking block is used.
*/
`timescale 1ns/1ns
interface core_pins_if;

  // ========================================================================
  // Test, clock enable, reset and miscellaneous pins.
  logic        scan_clock_force;
  logic        scan_shift_enable;
  logic [6:0]  scan_chain_in;
  logic [6:0]  scan_chain_out;
  logic        bus_clock_enable;
  logic        debug_clock_enable;
  logic        bus_reset_n;
  logic        debug_reset_n;
  logic        endian_big_out;
  logic        fast_irq_n;
  logic        normal_irq_n;
  logic        vector_init_strap;
  // Minimal bus write path driven by the core.
  logic        bus_valid;
  logic [31:0] bus_addr;
  logic [31:0] bus_wdata;
  logic [3:0]  bus_strb;

  modport dev (
    input  scan_clock_force, scan_shift_enable, scan_chain_in,
    input  bus_clock_enable, debug_clock_enable, bus_reset_n,
    input  debug_reset_n, fast_irq_n, normal_irq_n, vector_init_strap,
    output scan_chain_out, endian_big_out,
    output bus_valid, bus_addr, bus_wdata, bus_strb
  );

  modport sys (
    output scan_clock_force, scan_shift_enable, scan_chain_in,
    output bus_clock_enable, debug_clock_enable, bus_reset_n,
    output debug_reset_n, fast_irq_n, normal_irq_n, vector_init_strap,
    input  scan_chain_out, endian_big_out,
    input  bus_valid, bus_addr, bus_wdata, bus_strb
  );

endinterface : core_pins_if

// ### verilog/scan_chain.sv
/*
  One serial scan chain of parameterised length.
  Assumes shift_en is synchronous to pclk.
*/
`timescale 1ns/1ns
module scan_chain #(
  parameter int LEN = 16
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic shift_en,
  input  wire logic scan_in,
  output logic      scan_out
);

  logic [LEN-1:0] chain_q;
  logic [LEN-1:0] chain_d;

  // ========================================================================
  // Shift one place toward the output per enabled edge.
  always_comb
  begin
    chain_d = chain_q;
    if (shift_en)
    begin
      chain_d = {chain_q[LEN-2:0], scan_in}; // [RULE_15]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chain_q <= '0;
    end
    else
    begin
      chain_q <= chain_d;
    end
  end

  assign scan_out = chain_q[LEN-1];

endmodule : scan_chain

// ### verilog/core_pins_sys.sv
/*
  System integration end: APB slave whose registers drive the test,
  enable, reset, interrupt and strap pins, a bus enable divider, and a
  recorder of the core's bus writes.
  Assumes APB signals are synchronous to pclk.
*/
`timescale 1ns/1ns
`include "core_pins_regs.svh"
module core_pins_sys (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  core_pins_if.sys         link
);
  import core_pins_pkg::*;

  // ========================================================================
  // Register, divider, pin and recorder state in one group.
  logic [`CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [`DIV_W-1:0]  div_q, div_d, cnt_q, cnt_d;
  logic [6:0]         sin_q, sin_d;
  logic               shift_q, shift_d, ben_q, ben_d, dce_q, dce_d;
  logic [31:0]        ba_q, ba_d, bd_q, bd_d;
  logic [3:0]         bs_q, bs_d;
  logic               rdy_q, rdy_d, err_q, err_d;
  logic [31:0]        rd_q, rd_d;
  logic               acc, hit, wr;

  assign acc = psel & penable;
  assign wr  = acc & rdy_q & pwrite & !err_q;

  always_comb
  begin
    ctrl_d  = ctrl_q;
    div_d   = div_q;
    sin_d   = sin_q;
    ba_d    = ba_q;
    bd_d    = bd_q;
    bs_d    = bs_q;
    rd_d    = rd_q;
    err_d   = 1'b0;  // The error flag stands only beside pready.
    shift_d = 1'b0;
    // One wait state: the answer is prepared, then pready rises.
    rdy_d   = acc & !rdy_q;
    hit     = 1'b1;
    if (acc & !rdy_q)
    begin
      rd_d = '0;
      unique case (paddr)
        `REG_CTRL:     rd_d[`CTRL_W-1:0] = ctrl_q;
        `REG_DIV:      rd_d[`DIV_W-1:0]  = div_q;
        `REG_SCAN:     rd_d = {23'h0, link.endian_big_out,
                               1'b0, link.scan_chain_out};
        `REG_BUS_ADDR: rd_d = ba_q;
        `REG_BUS_DATA: rd_d = bd_q;
        `REG_BUS_STRB: rd_d[3:0] = bs_q;
        default:       hit = 1'b0;
      endcase
      err_d = !hit;
    end
    // Writes land only at the edge that samples pready high.
    if (wr)
    begin
      unique case (paddr)
        `REG_CTRL: ctrl_d = pwdata[`CTRL_W-1:0];
        `REG_DIV:  div_d  = pwdata[`DIV_W-1:0];
        `REG_SCAN:
        begin
          sin_d   = pwdata[6:0];
          // Shifting is only allowed while the scan clocks are forced.
          shift_d = ctrl_q[`CTRL_TEST];                          // [RULE_02]
        end
        default: ;
      endcase
    end
    // A zero divide ratio means the bus runs at core rate.
    cnt_d = (cnt_q >= div_q) ? '0 : cnt_q + 8'h01;
    ben_d = (div_d == '0) | (cnt_d == div_q);                    // [RULE_06]
    // The debug enable is forced high for the whole scan test.
    dce_d = ctrl_d[`CTRL_DBG_EN] | ctrl_d[`CTRL_TEST];           // [RULE_07]
    // Record a core write on a bus edge where it is presented.
    if (ben_q & link.bus_valid)
    begin
      ba_d = link.bus_addr;                                      // [RULE_05]
      bd_d = link.bus_wdata;
      bs_d = link.bus_strb;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q  <= `CTRL_RESET;
      div_q   <= `DIV_RESET;
      cnt_q   <= '0;
      sin_q   <= '0;
      shift_q <= 1'b0;
      ben_q   <= 1'b1;
      dce_q   <= 1'b0;
      ba_q    <= '0;
      bd_q    <= '0;
      bs_q    <= '0;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rd_q    <= '0;
    end
    else
    begin
      ctrl_q  <= ctrl_d;
      div_q   <= div_d;
      cnt_q   <= cnt_d;
      sin_q   <= sin_d;
      shift_q <= shift_d;
      ben_q   <= ben_d;
      dce_q   <= dce_d;
      ba_q    <= ba_d;
      bd_q    <= bd_d;
      bs_q    <= bs_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      rd_q    <= rd_d;
    end
  end

  // ========================================================================
  // Pin drive; run and request bits are stored active high.
  assign link.scan_clock_force   = ctrl_q[`CTRL_TEST];          // [RULE_01]
  assign link.scan_shift_enable  = shift_q;
  assign link.scan_chain_in      = sin_q;
  assign link.bus_clock_enable   = ben_q;
  assign link.debug_clock_enable = dce_q;
  assign link.bus_reset_n        = ctrl_q[`CTRL_BUS_RUN];
  assign link.debug_reset_n      = ctrl_q[`CTRL_DBG_RUN];
  assign link.fast_irq_n         = !ctrl_q[`CTRL_FIQ];
  assign link.normal_irq_n       = !ctrl_q[`CTRL_IRQ];
  assign link.vector_init_strap  = ctrl_q[`CTRL_STRAP];
  assign prdata                  = rd_q;
  assign pready                  = rdy_q;
  assign pslverr                 = err_q;

endmodule : core_pins_sys

// ### dv/core_pins_properties.sv
/*
  Checker on the link between the core end and the system end.
  Assumes it sits beside the link interface and sees pclk and presetn.
*/
`timescale 1ns/1ns
module core_pins_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        scan_clock_force,
  input wire logic        scan_shift_enable,
  input wire logic [6:0]  scan_chain_out,
  input wire logic        bus_clock_enable,
  input wire logic        debug_clock_enable,
  input wire logic        bus_reset_n,
  input wire logic        bus_valid,
  input wire logic [31:0] bus_wdata,
  input wire logic [3:0]  bus_strb
);
  // ========================================================================
  // Checks
  // Test mode turns every edge into a bus edge.
  logic bus_edge;
  assign bus_edge = bus_clock_enable | scan_clock_force;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SHIFT_PULSE: assert property (
    scan_shift_enable |=> !scan_shift_enable)
    else $error("shift enable held longer than one cycle");
  AST_SHIFT_IN_TEST: assert property (
    scan_shift_enable |-> scan_clock_force)
    else $error("shift enable outside test mode");
  AST_DBG_IN_TEST: assert property (
    scan_clock_force && $past(scan_clock_force) |-> debug_clock_enable)
    else $error("debug enable low during test mode");
  AST_ABORT: assert property (
    !bus_reset_n |=> !bus_valid)
    else $error("bus write survives bus reset");
  AST_RISE_ON_EDGE: assert property (
    $rose(bus_valid) |-> $past(bus_edge))
    else $error("bus write started off a bus edge");
  AST_HOLD: assert property (
    bus_valid && !bus_edge && bus_reset_n
    |=> bus_valid && $stable(bus_wdata))
    else $error("bus write changed between bus edges");
  AST_ONE_EDGE: assert property (
    bus_valid && bus_edge |=> !bus_valid)
    else $error("bus write held past its bus edge");
  AST_LANES: assert property (
    bus_valid |-> $onehot(bus_strb)
                  && bus_wdata == {4{bus_wdata[7:0]}})
    else $error("byte write lanes malformed");
  AST_SCAN_STILL: assert property (
    !scan_shift_enable |=> $stable(scan_chain_out))
    else $error("scan output moved without a shift");

  // Main scenarios reached.
  COV_WRITE: cover property (bus_valid && !bus_edge);
  COV_SHIFT: cover property (scan_shift_enable);
  COV_ABORT: cover property (bus_valid && !bus_reset_n);
endmodule : core_pins_properties

// ### dv/core_pins_tb.sv
/*
  Self-checking bench joining the core end and the system end.
  Assumes the design files under verilog/ are compiled first.
*/
`timescale 1ns/1ns
`include "core_pins_regs.svh"
module core_test_and_misc_pins_tb;
  import core_pins_pkg::*;
  // ========================================================================
  // Signals
  logic        pclk, presetn, psel, penable, pwrite, pslverr, pready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, t1;
  logic        big_endian_mode, xfer_req, xfer_busy, xfer_done, vbh, last_err;
  logic [31:0] xfer_addr, irq_vector;
  logic [7:0]  xfer_byte;
  logic [15:0] debug_ticks;
  irq_kind_t   irq_kind;
  int          fail_count, checks;

  core_pins_if link ();
  core_pins_dev #(.CHAIN_LEN(4)) i_core_pins_dev (.pclk(pclk),
    .presetn(presetn), .link(link), .big_endian_mode(big_endian_mode),
    .xfer_req(xfer_req), .xfer_addr(xfer_addr), .xfer_byte(xfer_byte),
    .xfer_busy(xfer_busy), .xfer_done(xfer_done), .vector_base_high(vbh),
    .irq_vector(irq_vector), .irq_kind(irq_kind),
    .debug_ticks(debug_ticks));
  core_pins_sys i_core_pins_sys (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  core_pins_properties i_core_pins_properties (.pclk(pclk),
    .presetn(presetn), .scan_clock_force(link.scan_clock_force),
    .scan_shift_enable(link.scan_shift_enable),
    .scan_chain_out(link.scan_chain_out),
    .bus_clock_enable(link.bus_clock_enable),
    .debug_clock_enable(link.debug_clock_enable),
    .bus_reset_n(link.bus_reset_n), .bus_valid(link.bus_valid),
    .bus_wdata(link.bus_wdata), .bus_strb(link.bus_strb));

  // ========================================================================
  // Helpers
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Lets registered outputs settle, then samples away from the edge.
  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  // One core byte write; req is dropped once it has been taken.
  task xfer(input logic [31:0] a, input logic [7:0] b);
    @(posedge pclk);
    xfer_req <= 1'b1;
    xfer_addr <= a;
    xfer_byte <= b;
    @(posedge pclk);
    xfer_req <= 1'b0;
    while (xfer_done !== 1'b1) @(posedge pclk);
  endtask : xfer

  // ========================================================================
  // Scenarios
  task t_reset;
    settle(1);
    chk(link.bus_reset_n, 0);
    chk({link.fast_irq_n, link.normal_irq_n}, 3);
    chk(link.bus_clock_enable, 1);
    apb(0, `REG_CTRL, 0);
    chk(rv, 0);
    apb(0, 12'h018, 0);
    chk({rv[30:0], last_err}, 1);
  endtask : t_reset

  // Strap taken during bus reset only; fast interrupt outranks normal.
  task t_vector;
    logic [31:0] off [3];
    off = '{`VEC_OFF_FIQ, `VEC_OFF_IRQ, `VEC_OFF_FIQ};
    apb(1, `REG_CTRL, 32'h20);
    apb(1, `REG_CTRL, 32'h22);
    apb(1, `REG_CTRL, 32'h02);
    settle(3);
    chk(vbh, 1);
    chk(irq_vector, `VEC_BASE_HIGH);
    for (int i = 0; i < 3; i++)
    begin
      apb(1, `REG_CTRL, 32'h02 | ((i + 1) << `CTRL_FIQ));
      settle(4);
      chk(irq_vector, `VEC_BASE_HIGH + off[i]);
      chk(irq_kind, (i == 1) ? IRQ_NORMAL : IRQ_FAST);
    end
    apb(1, `REG_CTRL, 32'h10);
    settle(4);
    chk(vbh, 0);
    chk(irq_vector, `VEC_BASE_LOW + `VEC_OFF_IRQ);
  endtask : t_vector

  // Every byte lane in both byte orders, slow bus for big-endian.
  task t_bus;
    logic [1:0] ln;
    apb(1, `REG_CTRL, 32'h02);
    for (int e = 0; e < 2; e++)
    begin
      big_endian_mode <= e[0];
      apb(1, `REG_DIV, 2 * e);
      settle(2);
      chk(link.endian_big_out, e);
      apb(0, `REG_SCAN, 0);
      chk(rv[`SCAN_ENDIAN], e);
      for (int l = 0; l < 4; l++)
      begin
        xfer(32'h1000_0040 + l, 8'hA0 + l);
        ln = e ? (2'h3 - l) : l;
        apb(0, `REG_BUS_ADDR, 0);
        chk(rv, 32'h1000_0040 + l);
        apb(0, `REG_BUS_DATA, 0);
        chk(rv, {4{8'hA0 + l[7:0]}});
        apb(0, `REG_BUS_STRB, 0);
        chk(rv, 32'h1 << ln);
      end
    end
    apb(1, `REG_DIV, 7);
    xfer_req <= 1'b1;
    apb(1, `REG_CTRL, 0);
    xfer_req <= 1'b0;
    settle(2);
    chk(xfer_busy, 0);
    apb(1, `REG_DIV, 0);
  endtask : t_bus

  // Ticks count enabled edges; debug reset clears them at once.
  task t_debug;
    apb(1, `REG_CTRL, 32'h46);
    settle(2);
    t1 = debug_ticks;
    settle(10);
    chk(debug_ticks, t1 + 10);
    apb(1, `REG_CTRL, 32'h42);
    settle(0);
    chk(debug_ticks, 0);
  endtask : t_debug

  // Four-deep chains: first pattern shows after four shifts.
  task t_scan;
    logic [6:0] v [5];
    v = '{7'h55, 7'h2A, 7'h0F, 7'h70, 7'h33};
    apb(1, `REG_CTRL, 32'h01);
    for (int i = 0; i < 5; i++)
    begin
      apb(1, `REG_SCAN, v[i]);
      settle(2);
      chk(link.debug_clock_enable, 1);
      apb(0, `REG_SCAN, 0);
      chk(rv[6:0], (i < 3) ? 0 : v[i - 3]);
    end
    apb(1, `REG_CTRL, 0);
    apb(1, `REG_SCAN, 7'h7F);
    settle(2);
    apb(0, `REG_SCAN, 0);
    chk(rv[6:0], v[1]);
  endtask : t_scan

  task end_of_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // ========================================================================
  // Clock, reset, sequence and watchdog.
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, xfer_req, big_endian_mode} = 0;
    {paddr, pwdata, xfer_addr, xfer_byte} = 0;
    {fail_count, checks} = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_vector();
    t_bus();
    t_debug();
    t_scan();
    end_of_test();
  end

  // Whole run needs well under this many cycles.
  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end
endmodule : core_test_and_misc_pins_tb
